// >>> verilog/runtime_regs_pkg.sv
// shared constants and types for the runtime watchdog, indicator and management-interrupt bank
package runtime_regs_pkg;

    // ****************************************************************
    // register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [7:0] IDX_PORT_GROUP4_DATA = 8'h0f;
    localparam logic [7:0] IDX_PORT_GROUP5_DATA = 8'h10;
    localparam logic [7:0] IDX_WATCHDOG_UNITS_SELECT = 8'h11;
    localparam logic [7:0] IDX_WATCHDOG_TIMEOUT_VALUE = 8'h12;
    localparam logic [7:0] IDX_WATCHDOG_IRQ_CONFIG = 8'h13;
    localparam logic [7:0] IDX_WATCHDOG_CONTROL_STATUS = 8'h14;
    localparam logic [7:0] IDX_INDICATOR_ONE_CONTROL = 8'h15;
    localparam logic [7:0] IDX_INDICATOR_TWO_CONTROL = 8'h16;
    localparam logic [7:0] IDX_RESERVED_SLOT = 8'h17;
    localparam logic [7:0] IDX_MGMT_IRQ_STATUS_THREE = 8'h18;
    localparam logic [7:0] IDX_MGMT_IRQ_ENABLE_THREE = 8'h19;
    localparam logic [7:0] IDX_MGMT_IRQ_ENABLE_TWO = 8'h0b;

    // ****************************************************************
    // field positions and codes
    // ****************************************************************
    localparam int UNITS_SECONDS_BIT = 7;
    localparam int CTRL_STATUS_BIT = 0;
    localparam int CTRL_FORCE_BIT = 2;
    localparam int STS3_WDT_BIT = 0;
    localparam int ROUTE_ENABLE_BIT = 7;
    localparam logic [3:0] IRQ_MAP_DISABLE = 4'h0;
    localparam logic [3:0] IRQ_MAP_INVALID = 4'h2;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [1:0] LED_OFF = 2'h0;
    localparam logic [1:0] LED_BLINK_FAST = 2'h1;
    localparam logic [1:0] LED_BLINK_SLOW = 2'h2;
    localparam logic [1:0] LED_ON = 2'h3;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam longint CLK_PERIOD_NS = 10;
    localparam longint HALF_SECOND_NS = 500000000;
    localparam longint HALF_SECOND_CYCLES = HALF_SECOND_NS / CLK_PERIOD_NS;
    localparam logic [5:0] SECONDS_PER_MINUTE_LAST = 6'h3b;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic half_tick;
        logic sec_tick;
        logic [1:0] phase;
    } timebase_type;

    typedef struct packed {
        logic [1:0] code;
    } led_ctrl_type;

endpackage

// >>> verilog/blink_timebase.sv
// half-second reference tick, second tick and two-second blink phase
`timescale 1ns/10ps
module blink_timebase
    import runtime_regs_pkg::*;
#(
    parameter int HALF_CYCLES = int'(HALF_SECOND_CYCLES)
) (
    input wire logic hclk,
    input wire logic hresetn,
    output timebase_type tb
);

    typedef struct packed {
        logic [31:0] count;
        logic [1:0] phase;
        logic half_tick;
        logic sec_tick;
    } tb_state_type;

    tb_state_type s_q;
    tb_state_type s_d;

    // free-running divider; phase walks 0..3 once per two seconds
    always_comb begin
        s_d = s_q;
        s_d.half_tick = 1'b0;
        s_d.sec_tick = 1'b0;
        if (s_q.count == 32'(HALF_CYCLES - 1)) begin
            s_d.count = 32'h0;
            s_d.half_tick = 1'b1;
            s_d.phase = s_q.phase + 2'h1;
            s_d.sec_tick = s_q.phase[0];
        end else begin
            s_d.count = s_q.count + 32'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tb.half_tick = s_q.half_tick;
    assign tb.sec_tick = s_q.sec_tick;
    assign tb.phase = s_q.phase;

endmodule

// >>> verilog/indicator_driver.sv
// one indicator output: off, on, or one of two blink patterns
`timescale 1ns/10ps
module indicator_driver
    import runtime_regs_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input led_ctrl_type ctrl,
    input wire logic [1:0] phase,
    output logic led
);

    typedef struct packed {
        logic led;
    } led_state_type;

    led_state_type s_q;
    led_state_type s_d;

    // fast blink: on in phases 0 and 2; slow blink: on in phase 0 only
    always_comb begin
        s_d = s_q;
        case (ctrl.code)
            LED_OFF: s_d.led = 1'b0;
            LED_BLINK_FAST: s_d.led = ~phase[0];
            LED_BLINK_SLOW: s_d.led = (phase == 2'h0);
            LED_ON: s_d.led = 1'b1;
            default: s_d.led = 1'b0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign led = s_q.led;

endmodule

// >>> verilog/runtime_wdt_led_smi_regs.sv
// runtime register bank: port data, watchdog, indicators, management interrupt
// Function
// - port group four data register, zero reset
// - port group five data register, zero reset
// - units bit selects minutes or seconds
// - zero timeout value disables the watchdog
// - nonzero value is binary count 1..255
// - config nibble maps timeout to request line
// - status bit reads one after timeout
// - force bit causes immediate timeout, self-clears
// - status held zero while value zero
// - watchdog registers clear on every reset
// - indicator code 00 off, 11 on
// - code 01 blinks 0.5s on 0.5s off
// - code 10 blinks 0.5s on 1.5s off
// - second indicator same coding, own output
// - status three: watchdog, serial3, serial4 bits
// - watchdog status bit clears on write one
// - enable three gates sources onto group interrupt
// - route enable passes group interrupt to pin
// - reserved bits and slot read zero
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/10ps
module runtime_wdt_led_smi_regs
    import runtime_regs_pkg::*;
#(
    parameter int HALF_CYCLES = int'(HALF_SECOND_CYCLES)
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic main_or_hard_reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic serial3_interrupt,
    input wire logic serial4_interrupt,
    output logic [7:0] port_group4_data,
    output logic [7:0] port_group5_data,
    output logic indicator_one,
    output logic indicator_two,
    output logic [15:0] watchdog_irq_lines,
    output logic mgmt_interrupt_pin_n
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic [7:0] grp4;
        logic [7:0] grp5;
        logic [7:0] units;
        logic [7:0] value;
        logic [7:0] cfg;
        logic wdt_sts;
        logic [1:0] ind1_code;
        logic [1:0] ind2_code;
        logic smi_wdt;
        logic [2:0] smi_en;
        logic route;
        logic [7:0] count;
        logic [5:0] sec_in_min;
        logic wr_pend;
        logic [7:0] widx;
        logic [31:0] rdata;
        logic [1:0] rst_sync;
        logic [1:0] u3_sync;
        logic [1:0] u4_sync;
        logic pin_n;
        logic [15:0] irq;
    } state_type;

    state_type s_q;
    state_type s_d;
    timebase_type tb;
    logic addr_ok;
    logic take;
    logic [7:0] aidx;
    logic [7:0] wd;
    logic unit_tick;
    logic expire;
    logic [2:0] sts3;
    logic [7:0] rd_val;

    // ****************************************************************
    // time base and indicators
    // ****************************************************************
    blink_timebase #(
        .HALF_CYCLES(HALF_CYCLES)
    ) u_timebase (
        .hclk(hclk),
        .hresetn(hresetn),
        .tb(tb)
    );

    indicator_driver u_led_one (
        .hclk(hclk),
        .hresetn(hresetn),
        .ctrl(led_ctrl_type'(s_q.ind1_code)),
        .phase(tb.phase),
        .led(indicator_one)
    );

    indicator_driver u_led_two (
        .hclk(hclk),
        .hresetn(hresetn),
        .ctrl(led_ctrl_type'(s_q.ind2_code)),
        .phase(tb.phase),
        .led(indicator_two)
    );

    // ****************************************************************
    // bus decode
    // ****************************************************************
    // only word-aligned addresses below the map's top decode; anything else reads zero
    assign aidx = haddr[9:2];
    assign addr_ok = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'h0);
    assign take = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign wd = hwdata[7:0];

    // status three view: serial bits follow their sources, cleared there
    // status bit layout
    assign sts3 = {s_q.u4_sync[1], s_q.u3_sync[1], s_q.smi_wdt};

    // read value, sampled in the address phase so hrdata comes from a flop
    always_comb begin
        rd_val = 8'h00;
        case (aidx)
            IDX_PORT_GROUP4_DATA: rd_val = s_q.grp4;
            IDX_PORT_GROUP5_DATA: rd_val = s_q.grp5;
            IDX_WATCHDOG_UNITS_SELECT: rd_val = s_q.units;
            IDX_WATCHDOG_TIMEOUT_VALUE: rd_val = s_q.value;
            IDX_WATCHDOG_IRQ_CONFIG: rd_val = s_q.cfg;
            // status in bit 0, force bit never reads back
            IDX_WATCHDOG_CONTROL_STATUS: rd_val = {7'h00, s_q.wdt_sts};
            IDX_INDICATOR_ONE_CONTROL: rd_val = {6'h00, s_q.ind1_code};
            IDX_INDICATOR_TWO_CONTROL: rd_val = {6'h00, s_q.ind2_code};
            IDX_MGMT_IRQ_STATUS_THREE: rd_val = {5'h00, sts3};
            IDX_MGMT_IRQ_ENABLE_THREE: rd_val = {5'h00, s_q.smi_en};
            IDX_MGMT_IRQ_ENABLE_TWO: rd_val = {s_q.route, 7'h00};
            // reserved slot and unmapped read zero
            default: rd_val = 8'h00;
        endcase
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        unit_tick = 1'b0;
        expire = 1'b0;
        // pins from outside the clock domain pass two flops first
        s_d.rst_sync = {s_q.rst_sync[0], main_or_hard_reset_n};
        s_d.u3_sync = {s_q.u3_sync[0], serial3_interrupt};
        s_d.u4_sync = {s_q.u4_sync[0], serial4_interrupt};

        // address phase: latch write intent and the read word
        s_d.wr_pend = take && hwrite && addr_ok;
        s_d.widx = aidx;
        if (take && !hwrite) begin
            s_d.rdata = addr_ok ? {24'h0, rd_val} : 32'h0;
        end

        // minute prescaler counts whole seconds
        if (tb.sec_tick) begin
            if (s_q.sec_in_min == SECONDS_PER_MINUTE_LAST) begin
                s_d.sec_in_min = 6'h0;
            end else begin
                s_d.sec_in_min = s_q.sec_in_min + 6'h1;
            end
        end
        // units select picks the decrement base
        if (s_q.units[UNITS_SECONDS_BIT]) begin
            unit_tick = tb.sec_tick;
        end else begin
            unit_tick = tb.sec_tick && (s_q.sec_in_min == SECONDS_PER_MINUTE_LAST);
        end

        // count down while running, timeout on the last unit
        if (unit_tick && !s_q.wdt_sts && s_q.count != 8'h00) begin
            s_d.count = s_q.count - 8'h01;
            if (s_q.count == 8'h01) begin
                expire = 1'b1;
            end
        end

        // data phase: apply the write
        if (s_q.wr_pend) begin
            case (s_q.widx)
                IDX_PORT_GROUP4_DATA: s_d.grp4 = wd;
                IDX_PORT_GROUP5_DATA: s_d.grp5 = wd;
                IDX_WATCHDOG_UNITS_SELECT: s_d.units = {wd[UNITS_SECONDS_BIT], 7'h00};
                IDX_WATCHDOG_TIMEOUT_VALUE: begin
                    s_d.value = wd;
                    if (wd != 8'h00) begin
                        s_d.count = wd;
                        s_d.wdt_sts = 1'b0;
                        s_d.sec_in_min = 6'h0;
                        expire = 1'b0;
                    end
                end
                IDX_WATCHDOG_IRQ_CONFIG: s_d.cfg = {wd[7:4], 4'h0};
                IDX_WATCHDOG_CONTROL_STATUS: begin
                    s_d.wdt_sts = wd[CTRL_STATUS_BIT];
                    // force bit is an event, never stored
                    if (wd[CTRL_FORCE_BIT]) begin
                        expire = 1'b1;
                    end
                end
                // only the two-bit field is kept
                IDX_INDICATOR_ONE_CONTROL: s_d.ind1_code = wd[1:0];
                IDX_INDICATOR_TWO_CONTROL: s_d.ind2_code = wd[1:0];
                // write one clears, zero leaves it
                IDX_MGMT_IRQ_STATUS_THREE: begin
                    if (wd[STS3_WDT_BIT]) begin
                        s_d.smi_wdt = 1'b0;
                    end
                end
                IDX_MGMT_IRQ_ENABLE_THREE: s_d.smi_en = wd[2:0];
                IDX_MGMT_IRQ_ENABLE_TWO: s_d.route = wd[ROUTE_ENABLE_BIT];
                default: s_d.smi_en = s_d.smi_en;
            endcase
        end

        // a zero value never times out
        if (s_d.value == 8'h00) begin
            expire = 1'b0;
            s_d.wdt_sts = 1'b0;
            s_d.count = 8'h00;
        end
        // timeout sets both status bits; set beats a same-cycle clear
        if (expire) begin
            s_d.wdt_sts = 1'b1;
            s_d.smi_wdt = 1'b1;
        end

        // main-supply or hard reset clears the watchdog registers
        if (!s_q.rst_sync[1]) begin
            s_d.units = REG_RESET;
            s_d.value = REG_RESET;
            s_d.cfg = REG_RESET;
            s_d.wdt_sts = 1'b0;
            s_d.count = 8'h00;
            s_d.sec_in_min = 6'h0;
        end

        // mapped request line follows the status; 0000 and 0010 drive nothing
        s_d.irq = 16'h0000;
        if (s_q.wdt_sts && s_q.cfg[7:4] != IRQ_MAP_DISABLE
            && s_q.cfg[7:4] != IRQ_MAP_INVALID) begin
            s_d.irq[s_q.cfg[7:4]] = 1'b1;
        end

        // enabled sources form the group interrupt
        // it reaches the pin only with routing enabled
        s_d.pin_n = ~(s_q.route && ((sts3 & s_q.smi_en) != 3'h0));
    end

    // one register stage for everything; aux-supply reset clears it all except pin_n, which resets high
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
            s_q.pin_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // zero-wait slave: the bus never stalls and never errors
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = s_q.rdata;
    assign port_group4_data = s_q.grp4;
    assign port_group5_data = s_q.grp5;
    assign watchdog_irq_lines = s_q.irq;
    assign mgmt_interrupt_pin_n = s_q.pin_n;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence force_write_seq;
        s_q.wr_pend && s_q.widx == IDX_WATCHDOG_CONTROL_STATUS && hwdata[CTRL_FORCE_BIT];
    endsequence

    sequence armed_seq;
        s_q.value != 8'h00 && s_q.rst_sync[1];
    endsequence

    a_disabled_no_status: assert property (s_q.value == 8'h00 |-> !s_q.wdt_sts)
        else $error("watchdog status set while disabled");

    a_force_timeout: assert property (force_write_seq and armed_seq |=> s_q.wdt_sts
        && s_q.smi_wdt)
        else $error("forced timeout did not set status");

    a_expire_status: assert property (unit_tick && s_q.count == 8'h01 && !s_q.wdt_sts
        && !s_q.wr_pend ##0 armed_seq |=> s_q.wdt_sts && s_q.smi_wdt)
        else $error("countdown end did not set status");

    a_restart_load: assert property (s_q.wr_pend && s_q.widx == IDX_WATCHDOG_TIMEOUT_VALUE
        && hwdata[7:0] != 8'h00 && s_q.rst_sync[1] |=> s_q.count == $past(hwdata[7:0])
        && !s_q.wdt_sts)
        else $error("value write did not restart count");

    a_sticky_smi: assert property (s_q.smi_wdt && !(s_q.wr_pend
        && s_q.widx == IDX_MGMT_IRQ_STATUS_THREE && hwdata[STS3_WDT_BIT]) |=> s_q.smi_wdt)
        else $error("watchdog management status lost");

    a_pin_route: assert property (!mgmt_interrupt_pin_n |-> $past(s_q.route)
        && $past((sts3 & s_q.smi_en) != 3'h0))
        else $error("management pin asserted without cause");

    a_reserved_read: assert property (take && !hwrite && addr_ok && aidx == IDX_RESERVED_SLOT
        |=> hrdata == 32'h0)
        else $error("reserved slot read nonzero");

    a_irq_invalid: assert property (watchdog_irq_lines[2] == 1'b0
        && watchdog_irq_lines[0] == 1'b0)
        else $error("invalid request line driven");

    a_grp4_write: assert property (s_q.wr_pend && s_q.widx == IDX_PORT_GROUP4_DATA
        |=> port_group4_data == $past(hwdata[7:0]))
        else $error("port group four write lost");

    a_hard_reset: assert property (!s_q.rst_sync[1] |=> s_q.value == 8'h00
        && s_q.units == 8'h00 && s_q.cfg == 8'h00)
        else $error("watchdog registers survived reset");

endmodule

// >>> tb/ahb_host_model.sv
// bus master model standing in for the host software
`timescale 1ns/10ps
module ahb_host_model
    import runtime_regs_pkg::*;
(
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    output logic hung
);
    logic [31:0] rd_data;
    event rd_ev;
    // idle bus from time zero, whole words only
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        hung = 1'b0;
    end
    // bounded wait for hready at a rising edge; a stuck slave flags hung
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1 && n < 64) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 64) hung <= 1'b1;
    endtask
    // single transfer, entered just after a rising edge
    task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        wait_ready();
        // idle in the data phase, so no back-to-back requests
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd_data = hrdata;
        if (!wr) -> rd_ev;
    endtask
endmodule

// >>> tb/runtime_wdt_led_smi_regs_tb.sv
// self-checking bench for the runtime register bank
`timescale 1ns/10ps
module runtime_wdt_led_smi_regs_tb;
    import runtime_regs_pkg::*;
    localparam int HC = 4;
    localparam logic [7:0] CTL = IDX_WATCHDOG_CONTROL_STATUS;
    localparam logic [7:0] VAL = IDX_WATCHDOG_TIMEOUT_VALUE;
    localparam logic [7:0] CFG = IDX_WATCHDOG_IRQ_CONFIG;
    localparam logic [7:0] STS = IDX_MGMT_IRQ_STATUS_THREE;
    localparam logic [7:0] EN3 = IDX_MGMT_IRQ_ENABLE_THREE;
    localparam logic [7:0] EN2 = IDX_MGMT_IRQ_ENABLE_TWO;
    logic hclk, hresetn, hard_n, s3, s4, hsel, hwrite, hreadyout, hresp, hung;
    logic ind1, ind2, pin_n;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] pg4, pg5;
    logic [15:0] irq;
    logic [31:0] haddr, hwdata, hrdata, rnd, c1, c2;
    logic [31:0] exp_q[$];
    int fail_count, num_checks;

    runtime_wdt_led_smi_regs #(.HALF_CYCLES(HC)) dut (
        .hclk(hclk), .hresetn(hresetn), .main_or_hard_reset_n(hard_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .serial3_interrupt(s3), .serial4_interrupt(s4), .port_group4_data(pg4),
        .port_group5_data(pg5), .indicator_one(ind1), .indicator_two(ind2),
        .watchdog_irq_lines(irq), .mgmt_interrupt_pin_n(pin_n));
    ahb_host_model host (
        .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hung(hung));

    // ****************************************************************
    // helpers
    // ****************************************************************
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // lit cycles over two full two-second blink periods per code
    function automatic logic [31:0] on_cnt(input int c);
        return (c == 3) ? 8 * HC : (c == 1) ? 4 * HC : (c == 2) ? 2 * HC : 0;
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] e);
        num_checks++;
        if (got !== e) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, e);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic fin(input string s);
        $display("end of test %s", s);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        host.xfer(1'b1, idx, d);
    endtask
    // the expected word is noted before the read goes out
    task automatic rd(input logic [7:0] idx, input logic [31:0] e);
        exp_q.push_back(e);
        host.xfer(1'b0, idx, 32'h0);
    endtask
    // read monitor pairs each returned word with the oldest note
    initial forever begin
        @(host.rd_ev);
        cmp(host.rd_data, exp_q.pop_front());
    end
    // a hang anywhere ends the run as a mismatch
    initial begin
        tick(5000);
        fail_count++;
        test_done();
    end
    always @(posedge hclk) begin
        if (hung === 1'b1) begin
            fail_count++;
            test_done();
        end
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        hresetn = 1'b0;
        hard_n = 1'b1;
        s3 = 1'b0;
        s4 = 1'b0;
        rnd = 32'h84a9a14f;
        tick(5);
        hresetn <= 1'b1;
        tick(1);
        for (int i = 15; i < 26; i++) rd(8'(i), 32'h0);
        rd(EN2, 32'h0);
        rd(8'hff, 32'h0);
        cmp({31'h0, hresp}, 32'h0);
        fin("reset");
        repeat (3) begin
            rnd = lfsr(rnd);
            wr(IDX_PORT_GROUP4_DATA, rnd);
            wr(IDX_PORT_GROUP5_DATA, ~rnd);
            rd(IDX_PORT_GROUP4_DATA, {24'h0, rnd[7:0]});
            rd(IDX_PORT_GROUP5_DATA, {24'h0, ~rnd[7:0]});
        end
        @(negedge hclk);
        cmp({16'h0, pg5, pg4}, {16'h0, ~rnd[7:0], rnd[7:0]});
        @(posedge hclk);
        wr(IDX_WATCHDOG_UNITS_SELECT, 32'hff);
        rd(IDX_WATCHDOG_UNITS_SELECT, 32'h80);
        wr(CFG, 32'hf3);
        rd(CFG, 32'hf0);
        wr(IDX_RESERVED_SLOT, 32'hff);
        rd(IDX_RESERVED_SLOT, 32'h0);
        wr(EN3, 32'hff);
        rd(EN3, 32'h7);
        wr(EN2, 32'hff);
        rd(EN2, 32'h80);
        fin("registers");
        // seconds base, count of two, then walk every mapping code
        wr(EN3, 32'h1);
        wr(VAL, 32'h2);
        rd(CTL, 32'h0);
        tick(40);
        rd(CTL, 32'h1);
        rd(STS, 32'h1);
        for (int c = 0; c < 16; c++) begin
            wr(CFG, 32'(c << 4));
            tick(2);
            @(negedge hclk);
            cmp({15'h0, pin_n, irq}, (c == 0 || c == 2) ? 32'h0 : 32'h1 << c);
            @(posedge hclk);
        end
        wr(STS, 32'h0);
        rd(STS, 32'h1);
        wr(STS, 32'h1);
        rd(STS, 32'h0);
        @(negedge hclk);
        cmp({31'h0, pin_n}, 32'h1);
        @(posedge hclk);
        fin("timeout");
        // force bit times out only with a nonzero value; at zero nothing is set
        wr(VAL, 32'h10);
        wr(CTL, 32'h0);
        rd(CTL, 32'h0);
        wr(CTL, 32'h4);
        rd(CTL, 32'h1);
        wr(VAL, 32'h0);
        rd(CTL, 32'h0);
        wr(CTL, 32'h4);
        rd(CTL, 32'h0);
        @(negedge hclk);
        cmp({16'h0, irq}, 32'h0);
        @(posedge hclk);
        fin("force");
        // minute base: no timeout before one minute, done within three
        wr(IDX_WATCHDOG_UNITS_SELECT, 32'h0);
        wr(VAL, 32'h2);
        tick(400);
        rd(CTL, 32'h0);
        tick(700);
        rd(CTL, 32'h1);
        fin("minutes");
        for (int c = 0; c < 4; c++) begin
            wr(IDX_INDICATOR_ONE_CONTROL, 32'(c));
            wr(IDX_INDICATOR_TWO_CONTROL, 32'(3 - c));
            tick(3);
            c1 = 32'h0;
            c2 = 32'h0;
            repeat (8 * HC) begin
                @(negedge hclk);
                c1 = c1 + ind1;
                c2 = c2 + ind2;
            end
            cmp(c1, on_cnt(c));
            cmp(c2, on_cnt(3 - c));
            @(posedge hclk);
        end
        fin("indicators");
        wr(STS, 32'h1);
        wr(EN2, 32'h0);
        wr(EN3, 32'h6);
        s3 <= 1'b1;
        s4 <= 1'b1;
        tick(4);
        rd(STS, 32'h6);
        @(negedge hclk);
        cmp({31'h0, pin_n}, 32'h1);
        @(posedge hclk);
        wr(EN2, 32'h80);
        tick(2);
        @(negedge hclk);
        cmp({31'h0, pin_n}, 32'h0);
        @(posedge hclk);
        wr(EN3, 32'h1);
        tick(2);
        @(negedge hclk);
        cmp({31'h0, pin_n}, 32'h1);
        @(posedge hclk);
        s3 <= 1'b0;
        s4 <= 1'b0;
        fin("serial");
        // main supply reset clears only the watchdog group; load nonzero state first
        wr(IDX_WATCHDOG_UNITS_SELECT, 32'h80);
        wr(VAL, 32'h5);
        wr(CTL, 32'h1);
        hard_n <= 1'b0;
        tick(4);
        hard_n <= 1'b1;
        tick(4);
        rd(VAL, 32'h0);
        rd(CTL, 32'h0);
        rd(CFG, 32'h0);
        rd(IDX_WATCHDOG_UNITS_SELECT, 32'h0);
        rd(IDX_PORT_GROUP4_DATA, {24'h0, rnd[7:0]});
        rd(EN3, 32'h1);
        fin("hard reset");
        tick(2);
        test_done();
    end
endmodule
